// ==== common/lsc_pkg.sv ====
// Constants, register map and state type for the link state controller
// Summary of operation
// - Three states shown on two status outputs
// - Transition needs two identical consecutive frame indications
// - Any error frame or reset holds acquisition 128 frames
// - Leave acquisition after 128 error-free frames only
// - Acquisition: training fill, interfaces off, frequency detect
// - Lock moves to waiting: acknowledge fill, phase detect
// - Acknowledge received while waiting enters data state
// - Data state: both interfaces on, phase detect
// - Decide from error, valid strobes, fill flag, state
// - Classify frames: training, acknowledge, data, error
// - Low data enable forces fill; select picks type
// - Detector disable low acquires; inactive ignores data
// - Either active-low reset forces acquisition state
// - Data enable retimed as ready-for-data indication
// - Two consecutive errors when locked lose lock
`default_nettype none
package lsc_pkg;
	typedef enum logic [1:0] {
		LSC_ACQ = 2'h0,
		LSC_WAIT = 2'h1,
		LSC_DATA = 2'h3
	} lsc_state_e;

	localparam int unsigned ADDR_W = 4;
	localparam int unsigned HOLD_FRAMES_DEF = 128;
	localparam int unsigned CNT_W_DEF = 8;

	// Frame classes reported by the receiver decode
	localparam logic [1:0] CLS_SQUARE = 2'h0;
	localparam logic [1:0] CLS_ACK = 2'h1;
	localparam logic [1:0] CLS_DATA = 2'h2;
	localparam logic [1:0] CLS_ERR = 2'h3;

	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_INT_STATUS = 4'h8;
	localparam logic [ADDR_W-1:0] REG_INT_MASK = 4'hc;

	localparam int unsigned CTRL_FORCE_BIT = 0;
	localparam logic CTRL_FORCE_RST = 1'h0;
	localparam int unsigned ST_STATE_LSB = 0;
	localparam int unsigned ST_HIGH_BIT = 2;
	localparam int unsigned ST_LOW_BIT = 3;
	localparam int unsigned ST_RESET_BIT = 4;
	localparam int unsigned ST_CNT_LSB = 8;
	localparam int unsigned INT_W = 3;
	localparam int unsigned INT_DATA_BIT = 0;
	localparam int unsigned INT_LOST_BIT = 1;
	localparam int unsigned INT_HOLD_BIT = 2;
	localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lsc_pkg
`default_nettype wire

// ==== hdl/lsc_link_state_ctrl.sv ====
// Link startup state controller with AXI4-Lite registers and interrupt
`timescale 1ns/1ps
`default_nettype none
module lsc_link_state_ctrl #(
	parameter int unsigned HOLD_FRAMES = lsc_pkg::HOLD_FRAMES_DEF,
	parameter int unsigned CNT_W = lsc_pkg::CNT_W_DEF
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic frameValid,
	input wire logic errorFlag,
	input wire logic dataWordValidN,
	input wire logic ctrlWordValidN,
	input wire logic fillWordFlag,
	input wire logic smResetAN,
	input wire logic smResetBN,
	output logic stateHighOut,
	output logic stateLowOut,
	output logic fillForceN,
	output logic fillTypeSel,
	output logic freqDetDisable,
	output logic rxActive,
	output logic readyForData,
	output logic irq,
	input wire logic [lsc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [lsc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import lsc_pkg::*;

	generate
		if (HOLD_FRAMES < 2 || HOLD_FRAMES >= (1 << CNT_W) || CNT_W > 23) begin : gBadParam
			$error("HOLD_FRAMES must be at least 2 and fit in CNT_W bits");
		end
	endgenerate

	localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_FRAMES);

	function automatic logic [1:0] classify(input logic err, input logic davN,
			input logic cavN, input logic fw);
		if (err)
			classify = CLS_ERR;
		else if (!davN || !cavN)
			classify = CLS_DATA;
		else if (fw)
			classify = CLS_ACK;
		else
			classify = CLS_SQUARE;
	endfunction : classify

	// Reset pin synchronisers, three stages each
	logic [2:0] resASync_r;
	logic [2:0] resBSync_r;
	logic resAFilt_r;
	logic resBFilt_r;

	always_ff @(posedge mclk) begin
		if (reset) begin
			resASync_r <= 3'h0;
			resBSync_r <= 3'h0;
			resAFilt_r <= 1'h0;
			resBFilt_r <= 1'h0;
		end else begin
			resASync_r <= {resASync_r[1:0], smResetAN};
			resBSync_r <= {resBSync_r[1:0], smResetBN};
			if (resASync_r[1] == resASync_r[2])
				resAFilt_r <= resASync_r[2];
			if (resBSync_r[1] == resBSync_r[2])
				resBFilt_r <= resBSync_r[2];
		end
	end

	logic ctrlForce_r;
	logic [INT_W-1:0] intStatus_r;
	logic [INT_W-1:0] intMask_r;

	// Frame decode and debounce
	logic [1:0] frameCls;
	logic [1:0] prevCls_r;
	logic prevValid_r;
	logic sameTwice;
	logic twoErr;
	logic resetHeld;
	logic forceAcq;

	assign frameCls = classify(errorFlag, dataWordValidN, ctrlWordValidN,
		fillWordFlag);
	assign sameTwice = frameValid && prevValid_r && (frameCls == prevCls_r);
	assign twoErr = sameTwice && (frameCls == CLS_ERR);
	// Either filtered reset pin holds acquisition
	assign resetHeld = !resAFilt_r || !resBFilt_r;
	assign forceAcq = resetHeld || ctrlForce_r;

	always_ff @(posedge mclk) begin
		if (reset || resetHeld) begin
			prevCls_r <= CLS_ERR;
			prevValid_r <= 1'h0;
		end else if (frameValid) begin
			prevCls_r <= frameCls;
			prevValid_r <= 1'h1;
		end
	end

	// Error-free frame counter gating exit from acquisition
	logic [CNT_W-1:0] frameCnt_r;
	logic [CNT_W-1:0] frameCnt_nxt;
	logic holdDone;

	assign holdDone = (frameCnt_r >= HOLD_CNT);
	assign frameCnt_nxt = (forceAcq || (frameValid && frameCls == CLS_ERR)) ?
		'0 : (frameValid && !holdDone) ? frameCnt_r + 1'b1 : frameCnt_r;

	always_ff @(posedge mclk) begin
		if (reset)
			frameCnt_r <= '0;
		else
			frameCnt_r <= frameCnt_nxt;
	end

	// Link state machine
	lsc_state_e state_r;
	lsc_state_e state_nxt;
	logic lockSeen;

	// Two matching fill frames stand for receiver lock
	assign lockSeen = sameTwice &&
		(frameCls == CLS_SQUARE || frameCls == CLS_ACK);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			LSC_ACQ: begin
				if (!forceAcq && holdDone && lockSeen)
					state_nxt = LSC_WAIT;
			end
			LSC_WAIT: begin
				if (forceAcq || twoErr)
					state_nxt = LSC_ACQ;
				else if (sameTwice && frameCls == CLS_ACK)
					state_nxt = LSC_DATA;
			end
			LSC_DATA: begin
				if (forceAcq || twoErr)
					state_nxt = LSC_ACQ;
			end
			default: state_nxt = LSC_ACQ;
		endcase
	end

	// Status pins follow the next state so they stay registered
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_r <= LSC_ACQ;
			stateHighOut <= 1'h0;
			stateLowOut <= 1'h0;
			fillForceN <= 1'h0;
			fillTypeSel <= 1'h0;
			freqDetDisable <= 1'h0;
			rxActive <= 1'h0;
			readyForData <= 1'h0;
		end else begin
			state_r <= state_nxt;
			stateHighOut <= (state_nxt != LSC_ACQ);
			stateLowOut <= (state_nxt == LSC_DATA);
			fillForceN <= (state_nxt == LSC_DATA);
			fillTypeSel <= (state_nxt != LSC_ACQ);
			freqDetDisable <= (state_nxt != LSC_ACQ);
			rxActive <= (state_nxt != LSC_ACQ);
			readyForData <= fillForceN;
		end
	end

	// Interrupt events
	logic [INT_W-1:0] intSet;
	logic [INT_W-1:0] intClr;

	assign intSet[INT_DATA_BIT] = (state_r == LSC_WAIT) && (state_nxt == LSC_DATA);
	assign intSet[INT_LOST_BIT] = (state_r != LSC_ACQ) && (state_nxt == LSC_ACQ);
	assign intSet[INT_HOLD_BIT] = twoErr;

	// AXI4-Lite write path: address and data taken in either order
	logic awHeld_r;
	logic wHeld_r;
	logic [ADDR_W-1:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic doWrite;
	logic wrMapped;
	logic awTake;
	logic wTake;

	assign awTake = s_axi_awvalid && s_axi_awready;
	assign wTake = s_axi_wvalid && s_axi_wready;
	assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
	// STATUS takes writes but keeps its value
	assign wrMapped = (awAddr_r == REG_CTRL) || (awAddr_r == REG_INT_STATUS) ||
		(awAddr_r == REG_INT_MASK) || (awAddr_r == REG_STATUS);
	assign intClr = (doWrite && awAddr_r == REG_INT_STATUS && wStrb_r[0]) ?
		wData_r[INT_W-1:0] : '0;

	always_ff @(posedge mclk) begin
		if (reset) begin
			awHeld_r <= 1'h0;
			wHeld_r <= 1'h0;
			awAddr_r <= '0;
			wData_r <= 32'h0;
			wStrb_r <= 4'h0;
			s_axi_awready <= 1'h0;
			s_axi_wready <= 1'h0;
			s_axi_bvalid <= 1'h0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			// Ready stays low while a request is held
			s_axi_awready <= !awHeld_r && !awTake && !doWrite;
			s_axi_wready <= !wHeld_r && !wTake && !doWrite;
			if (awTake) begin
				awHeld_r <= 1'h1;
				awAddr_r <= s_axi_awaddr;
			end
			if (wTake) begin
				wHeld_r <= 1'h1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_r <= 1'h0;
				wHeld_r <= 1'h0;
				s_axi_bvalid <= 1'h1;
				s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'h0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrlForce_r <= CTRL_FORCE_RST;
			intMask_r <= INT_MASK_RST;
			intStatus_r <= '0;
			irq <= 1'h0;
		end else begin
			if (doWrite && awAddr_r == REG_CTRL && wStrb_r[0])
				ctrlForce_r <= wData_r[CTRL_FORCE_BIT];
			if (doWrite && awAddr_r == REG_INT_MASK && wStrb_r[0])
				intMask_r <= wData_r[INT_W-1:0];
			// Set wins over a simultaneous clear
			intStatus_r <= (intStatus_r & ~intClr) | intSet;
			irq <= |(((intStatus_r & ~intClr) | intSet) & intMask_r);
		end
	end

	// AXI4-Lite read path
	logic [31:0] rdMux;
	logic rdMapped;
	logic [31:0] statusWord;

	assign statusWord = {{(24 - CNT_W){1'b0}}, frameCnt_r, 3'h0, resetHeld,
		stateLowOut, stateHighOut, state_r};
	assign rdMapped = (s_axi_araddr == REG_CTRL) ||
		(s_axi_araddr == REG_STATUS) || (s_axi_araddr == REG_INT_STATUS) ||
		(s_axi_araddr == REG_INT_MASK);
	assign rdMux = (s_axi_araddr == REG_CTRL) ? {31'h0, ctrlForce_r} :
		(s_axi_araddr == REG_STATUS) ? statusWord :
		(s_axi_araddr == REG_INT_STATUS) ? {29'h0, intStatus_r} :
		(s_axi_araddr == REG_INT_MASK) ? {29'h0, intMask_r} : 32'h0;

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_arready <= 1'h0;
			s_axi_rvalid <= 1'h0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			// Address handshake first, data one edge later
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'h1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'h0;
			end
		end
	end
endmodule : lsc_link_state_ctrl
`default_nettype wire

// ==== tb/lsc_remote_tx.sv ====
// Remote transmitter model sending one frame class per request
`timescale 1ns/1ps
`default_nettype none
module lsc_remote_tx (
	input wire logic mclk,
	input wire logic send,
	input wire logic [1:0] cls,
	output logic frameValid,
	output logic errorFlag,
	output logic dataWordValidN,
	output logic ctrlWordValidN,
	output logic fillWordFlag
);
	import lsc_pkg::*;
	logic ctrlTurn;
	initial {frameValid, errorFlag, dataWordValidN, ctrlWordValidN,
		fillWordFlag, ctrlTurn} = 6'h0;
	// Idle lines toggle so stale levels never pass for a frame
	// Data frames alternate between data and control words
	always @(posedge mclk) begin
		frameValid <= send;
		if (send && cls == CLS_DATA) ctrlTurn <= !ctrlTurn;
		errorFlag <= send ? cls == CLS_ERR : !errorFlag;
		dataWordValidN <= send ? !(cls == CLS_DATA && !ctrlTurn) :
			!dataWordValidN;
		ctrlWordValidN <= send ? !(cls == CLS_DATA && ctrlTurn) :
			!ctrlWordValidN;
		fillWordFlag <= send ? cls == CLS_ACK : !fillWordFlag;
	end
endmodule : lsc_remote_tx
`default_nettype wire

// ==== tb/lsc_monitor.sv ====
// Port checker for the link state controller
`timescale 1ns/1ps
`default_nettype none
module lsc_monitor #(
	parameter int unsigned HOLD_FRAMES = 128
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic frameValid,
	input wire logic errorFlag,
	input wire logic dataWordValidN,
	input wire logic ctrlWordValidN,
	input wire logic fillWordFlag,
	input wire logic smResetAN,
	input wire logic stateHighOut,
	input wire logic stateLowOut,
	input wire logic fillForceN,
	input wire logic fillTypeSel,
	input wire logic freqDetDisable,
	input wire logic rxActive,
	input wire logic readyForData
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	int goodCnt;
	wire fillF = frameValid & ~errorFlag & dataWordValidN & ctrlWordValidN;
	wire errF = frameValid & errorFlag;
	// Error-free frames since the last error frame
	always_ff @(posedge mclk) begin
		if (reset || errF) goodCnt <= 0;
		else if (frameValid) goodCnt <= goodCnt + 1;
	end
	sequence twoErr;
		(stateHighOut && errF) ##1 errF;
	endsequence
	state_code_a: assert property (stateLowOut |-> stateHighOut)
		else $error("data state without waiting bit");
	pin_map_a: assert property (fillForceN == stateLowOut
		&& {fillTypeSel, freqDetDisable, rxActive} == {3{stateHighOut}})
		else $error("control pins disagree with state");
	ready_retime_a: assert property (readyForData == $past(fillForceN))
		else $error("ready indication not retimed");
	lock_enter_a: assert property ($rose(stateHighOut)
		|-> $past(fillF) && goodCnt >= HOLD_FRAMES)
		else $error("left acquisition too early");
	data_enter_a: assert property ($rose(stateLowOut)
		|-> $past(fillF && fillWordFlag))
		else $error("data state without acknowledge fill");
	lock_lost_a: assert property (twoErr |=> !stateHighOut)
		else $error("two errors did not drop lock");
	sm_reset_a: assert property (!smResetAN |-> ##[1:6] !stateHighOut)
		else $error("state reset did not reach acquisition");
	acq_hold_a: assert property (!stateHighOut && frameValid && !fillF
		|=> !stateHighOut) else $error("non-fill frame left acquisition");
endmodule : lsc_monitor
`default_nettype wire

// ==== tb/lsc_link_startup_state_machine_bench.sv ====
// Self-checking bench for the link state controller
`timescale 1ns/1ps
`default_nettype none
module lsc_link_startup_state_machine_bench;
	import lsc_pkg::*;
	localparam int HOLD = 4;
	localparam logic [31:0] ST_WAIT = 32'((HOLD << ST_CNT_LSB) |
		(1 << ST_HIGH_BIT) | int'(LSC_WAIT));
	logic mclk, reset, send, frameValid, errorFlag, dataWordValidN, irq;
	logic ctrlWordValidN, fillWordFlag, smResetAN, smResetBN, rxActive;
	logic stateHighOut, stateLowOut, fillForceN, fillTypeSel;
	logic freqDetDisable, readyForData, s_axi_awvalid, s_axi_awready;
	logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] cls, s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
	logic [2:0] prev;
	logic [2:0] oq[$];
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int fails, compares;
	lsc_link_state_ctrl #(.HOLD_FRAMES(HOLD)) DUT (.mclk, .reset,
		.frameValid, .errorFlag, .dataWordValidN, .ctrlWordValidN,
		.fillWordFlag, .smResetAN, .smResetBN, .stateHighOut, .stateLowOut,
		.fillForceN, .fillTypeSel, .freqDetDisable, .rxActive, .readyForData,
		.irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	lsc_remote_tx remote (.mclk, .send, .cls, .frameValid, .errorFlag,
		.dataWordValidN, .ctrlWordValidN, .fillWordFlag);
	always #4 mclk = ~mclk;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic print_verdict;
		if (fails == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	task automatic tmo(input int i);
		if (i >= 100) begin
			fails++;
			print_verdict();
		end
	endtask : tmo
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int i;
		bq.push_back(r);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 100 && !s_axi_bvalid; i++) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		tmo(i);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		int i;
		rq.push_back(e);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 100 && !s_axi_rvalid; i++) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		tmo(i);
	endtask : rd
	task automatic fr(input logic [1:0] c, input int n);
		repeat (n) begin
			@(posedge mclk);
			send <= 1'b1;
			cls <= c;
		end
		@(posedge mclk);
		send <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask : fr
	// Each result is checked against the oldest note when it appears
	always @(posedge mclk) begin
		if (reset) prev <= 3'h0;
		else begin
			if (s_axi_rvalid && s_axi_rready)
				cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
			if (s_axi_bvalid && s_axi_bready)
				cmp(34'(s_axi_bresp), 34'(bq.pop_front()));
			if ({irq, stateHighOut, stateLowOut} !== prev)
				cmp(34'({irq, stateHighOut, stateLowOut}),
					34'(oq.pop_front()));
			prev <= {irq, stateHighOut, stateLowOut};
		end
	end
	initial begin
		int k;
		{mclk, send, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h0;
		{reset, smResetAN, smResetBN, cls, s_axi_wdata} = {3'h7, 34'h0};
		s_axi_wstrb = 4'hf;
		rnd = 32'h91bf;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		repeat (8) @(posedge mclk);
		fr(CLS_SQUARE, 3);
		fr(CLS_ERR, 1);
		fr(CLS_SQUARE, HOLD);
		oq.push_back(3'b010);
		fr(CLS_SQUARE, 1);
		fr(CLS_ACK, 1);
		fr(CLS_DATA, 1);
		oq.push_back(3'b011);
		fr(CLS_ACK, 2);
		fr(CLS_ERR, 1);
		fr(CLS_DATA, 1);
		oq.push_back(3'b000);
		fr(CLS_ERR, 2);
		rd(REG_INT_STATUS, {RESP_OKAY, 32'h7});
		rnd = lfsr(rnd);
		oq.push_back(3'b100);
		wr(REG_INT_MASK, {rnd[31:3], 3'h7}, RESP_OKAY);
		rd(REG_INT_MASK, {RESP_OKAY, 32'h7});
		s_axi_wstrb <= {rnd[3:1], 1'b0};
		wr(REG_INT_MASK, 32'h0, RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(REG_INT_MASK, {RESP_OKAY, 32'h7});
		wr(REG_INT_STATUS, 32'h5, RESP_OKAY);
		rd(REG_INT_STATUS, {RESP_OKAY, 32'h2});
		oq.push_back(3'b000);
		wr(REG_INT_STATUS, 32'h2, RESP_OKAY);
		rd(4'h6, {RESP_SLVERR, 32'h0});
		wr(4'h6, 32'h7, RESP_SLVERR);
		for (k = 0; k < 3; k++) begin
			oq.push_back({k != 0, 2'b10});
			fr(CLS_SQUARE, HOLD + 2);
			rd(REG_STATUS, {RESP_OKAY, ST_WAIT});
			oq.push_back(3'b100);
			if (k == 0) smResetAN <= 1'b0;
			else if (k == 1) smResetBN <= 1'b0;
			else begin
				wr(REG_CTRL, 32'h1, RESP_OKAY);
				rd(REG_CTRL, {RESP_OKAY, 32'h1});
				wr(REG_CTRL, 32'h0, RESP_OKAY);
			end
			repeat (8) @(posedge mclk);
			smResetAN <= 1'b1;
			smResetBN <= 1'b1;
			repeat (8) @(posedge mclk);
		end
		cmp(34'(oq.size() + rq.size() + bq.size()), 34'h0);
		print_verdict();
	end
endmodule : lsc_link_startup_state_machine_bench
bind lsc_link_state_ctrl lsc_monitor #(.HOLD_FRAMES(HOLD_FRAMES)) chk (
	.mclk, .reset, .frameValid, .errorFlag, .dataWordValidN,
	.ctrlWordValidN, .fillWordFlag, .smResetAN, .stateHighOut, .stateLowOut,
	.fillForceN, .fillTypeSel, .freqDetDisable, .rxActive, .readyForData);
`default_nettype wire
